//--- verilog/tor_pkg.sv
/*
  Package for the torque-off request, acknowledgement and restart control block.
  Assumes a single 250 MHz system clock and a synchronous active-high reset.
*/
package tor_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 250_000_000;
  localparam int CYCLES_PER_MS = CLK_FREQ_HZ / 1000;
  localparam int RESTART_DELAY_MS = 2000;
  localparam int TIME_TO_ZERO_MS = 2000;
  localparam int RESTART_DELAY_CYC = RESTART_DELAY_MS * CYCLES_PER_MS;
  localparam int TIME_TO_ZERO_CYC = TIME_TO_ZERO_MS * CYCLES_PER_MS;
  localparam int TIMER_W = 32;

  // ---------------------------------------------------------------------------
  // Input selection
  // ---------------------------------------------------------------------------
  localparam int NUM_DI = 4;
  localparam int SEL_W = 3;
  localparam logic [SEL_W-1:0] SEL_NONE = 3'h0;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESTART_DLY = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_ZERO_TIME = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 4'h4;

  // CFG fields
  localparam int CFG_EXT_TYPE_LSB = 0;
  localparam int CFG_RAMP_TYPE_LSB = 2;
  localparam int CFG_ACK_MANUAL_BIT = 4;
  localparam int CFG_EMERG_BIT = 5;
  localparam int CFG_PRI_SEL_LSB = 8;
  localparam int CFG_SEC_SEL_LSB = 12;
  localparam int CFG_S1_SEL_LSB = 16;
  localparam int CFG_ACK_SEL_LSB = 20;
  localparam int CFG_CAT0_BIT = 24;
  localparam logic [31:0] CFG_RESET = 32'h0100_2000;

  // STATUS fields
  localparam int ST_TORQUE_OFF_BIT = 0;
  localparam int ST_COMPLETE_BIT = 1;
  localparam int ST_FAULTED_BIT = 2;
  localparam int ST_RESTART_OK_BIT = 3;
  localparam int ST_STATE_LSB = 4;

  // CMD fields
  localparam int CMD_FAULT_RESET_BIT = 0;

  typedef enum logic [1:0] {
    EV_NONE,
    EV_WARNING,
    EV_EVENT,
    EV_FAULT
  } tor_event_t;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_INPUT,
    SRC_STOP1,
    SRC_INTERNAL
  } tor_src_t;

endpackage : tor_pkg

//--- verilog/tor_control.sv
/*
  Torque-off request, acknowledgement and restart control.
  Assumes digital inputs are asynchronous pins, ramp and fault flags come from
  same-clock logic, and a plain register port driven by a synchronous master.
*/
module tor_control
  import tor_pkg::*;
#(
  parameter int RESTART_DELAY_DEF = RESTART_DELAY_CYC,
  parameter int TIME_TO_ZERO_DEF = TIME_TO_ZERO_CYC
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [NUM_DI-1:0] digIn, // Safety digital input pins, high is request
  input wire logic overTemp, // Overtemperature condition
  input wire logic rampLimitHit, // Stop-1 ramp or time limit exceeded
  input wire logic internalFault, // Internal fault detected
  input wire logic [ADDR_W-1:0] regAddr, // Register address
  input wire logic [31:0] regWdata, // Register write data
  input wire logic regWr, // Register write strobe
  input wire logic regRd, // Register read strobe
  output logic [31:0] regRdata, // Register read data
  output logic torqueOff, // Safe torque off active
  output logic torqueOffComplete, // Torque off completed
  output logic restartAllowed, // Restart permitted
  output logic eventValid, // Event pulse to drive
  output logic [1:0] eventType, // Event severity
  output logic driveFaulted // Drive held faulted
);

  // ---------------------------------------------------------------------------
  // Registers and input synchronisers
  // ---------------------------------------------------------------------------
  logic [31:0] cfg_q;
  logic [TIMER_W-1:0] restartDly_q;
  logic [TIMER_W-1:0] zeroTime_q;
  logic [NUM_DI-1:0] diMeta_q;
  logic [NUM_DI-1:0] diSync_q;
  logic [NUM_DI-1:0] diPrev_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      diMeta_q <= '0;
      diSync_q <= '0;
      diPrev_q <= '0;
    end else begin
      diMeta_q <= digIn;
      diSync_q <= diMeta_q;
      diPrev_q <= diSync_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------------------
  wire [1:0] extType = cfg_q[CFG_EXT_TYPE_LSB +: 2];
  wire [1:0] rampType = cfg_q[CFG_RAMP_TYPE_LSB +: 2];
  wire emergMode = cfg_q[CFG_EMERG_BIT];
  wire ackManual = cfg_q[CFG_ACK_MANUAL_BIT] | emergMode;
  wire [SEL_W-1:0] priSel = cfg_q[CFG_PRI_SEL_LSB +: SEL_W];
  wire [SEL_W-1:0] secSel = cfg_q[CFG_SEC_SEL_LSB +: SEL_W];
  wire [SEL_W-1:0] s1Sel = cfg_q[CFG_S1_SEL_LSB +: SEL_W];
  wire [SEL_W-1:0] ackSel = cfg_q[CFG_ACK_SEL_LSB +: SEL_W];
  wire cat0 = cfg_q[CFG_CAT0_BIT];

  // Selection value n picks input n-1; zero means unassigned
  function automatic logic pickIn(input logic [SEL_W-1:0] sel, input logic [NUM_DI-1:0] v);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_DI; i++) begin
      if (sel == SEL_W'(i + 1)) begin
        r = v[i];
      end
    end
    return r;
  endfunction : pickIn

  wire priReq = (priSel != SEL_NONE) & pickIn(priSel, diSync_q);
  wire secReq = (secSel != SEL_NONE) & pickIn(secSel, diSync_q);
  wire s1Req = (s1Sel != SEL_NONE) & pickIn(s1Sel, diSync_q);
  wire ackLvl = pickIn(ackSel, diSync_q);
  wire ackRise = (ackSel != SEL_NONE) & ackLvl & ~pickIn(ackSel, diPrev_q);
  wire inputReq = priReq | secReq | (cat0 & overTemp);
  wire anyReq = inputReq | s1Req | internalFault;

  // ---------------------------------------------------------------------------
  // Control state machine
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN,
    ST_STOP1,
    ST_OFF
  } tor_state_t;

  tor_state_t state_q;
  tor_src_t src_q;
  logic [TIMER_W-1:0] dlyCnt_q;
  logic [TIMER_W-1:0] zeroCnt_q;
  logic complete_q;
  logic faulted_q;
  logic evValid_q;
  logic [1:0] evType_q;

  wire faultReset = regWr & (regAddr == ADDR_CMD) & regWdata[CMD_FAULT_RESET_BIT];
  wire dlyDone = (src_q != SRC_INPUT) | (dlyCnt_q >= restartDly_q);
  wire ackOk = ackManual ? ackRise : ~anyReq;
  wire relOk = (state_q == ST_OFF) & ~anyReq & ackOk & dlyDone & ~faulted_q;
  wire enterOffIn = (state_q != ST_OFF) & (inputReq | internalFault);
  wire enterOffRamp = (state_q == ST_STOP1) & rampLimitHit & ~inputReq & ~internalFault;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_RUN;
      src_q <= SRC_NONE;
      evValid_q <= 1'b0;
      evType_q <= 2'h0;
    end else begin
      evValid_q <= 1'b0;
      case (state_q)
        ST_RUN: begin
          if (enterOffIn) begin
            state_q <= ST_OFF;
            src_q <= internalFault ? SRC_INTERNAL : SRC_INPUT;
            evValid_q <= ~internalFault;
            evType_q <= extType;
          end else if (s1Req) begin
            state_q <= ST_STOP1;
            src_q <= SRC_STOP1;
          end
        end
        ST_STOP1: begin
          if (enterOffIn) begin
            state_q <= ST_OFF;
            src_q <= internalFault ? SRC_INTERNAL : SRC_INPUT;
            evValid_q <= ~internalFault;
            evType_q <= extType;
          end else if (enterOffRamp) begin
            state_q <= ST_OFF;
            evValid_q <= 1'b1;
            evType_q <= rampType;
          end else if (!s1Req) begin
            state_q <= ST_RUN;
            src_q <= SRC_NONE;
          end
        end
        ST_OFF: begin
          if (relOk) begin
            state_q <= ST_RUN;
            src_q <= SRC_NONE;
          end
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Timers, completion and fault latch
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dlyCnt_q <= '0;
      zeroCnt_q <= '0;
      complete_q <= 1'b0;
      faulted_q <= 1'b0;
    end else begin
      // Clear on release too, so completion never shows outside torque off
      if (state_q != ST_OFF || relOk) begin
        dlyCnt_q <= '0;
        zeroCnt_q <= '0;
        complete_q <= 1'b0;
      end else begin
        if (dlyCnt_q < restartDly_q) begin
          dlyCnt_q <= dlyCnt_q + 1'b1;
        end
        if (zeroCnt_q < zeroTime_q) begin
          zeroCnt_q <= zeroCnt_q + 1'b1;
        end else begin
          complete_q <= 1'b1;
        end
      end
      // Fault event latches; a new fault beats a reset in the same cycle
      if (evValid_q & (evType_q == EV_FAULT)) begin
        faulted_q <= 1'b1;
      end else if (faultReset) begin
        faulted_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------------------
  wire [31:0] statusWord = {26'h0, state_q, restartAllowed, faulted_q, complete_q, torqueOff};
  wire [31:0] rdMux = (regAddr == ADDR_CFG) ? cfg_q :
                      (regAddr == ADDR_RESTART_DLY) ? restartDly_q :
                      (regAddr == ADDR_ZERO_TIME) ? zeroTime_q :
                      (regAddr == ADDR_STATUS) ? statusWord : 32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_q <= CFG_RESET;
      restartDly_q <= TIMER_W'(RESTART_DELAY_DEF);
      zeroTime_q <= TIMER_W'(TIME_TO_ZERO_DEF);
      regRdata <= 32'h0000_0000;
    end else begin
      if (regWr && regAddr == ADDR_CFG) begin
        cfg_q <= regWdata;
      end
      if (regWr && regAddr == ADDR_RESTART_DLY) begin
        restartDly_q <= regWdata;
      end
      if (regWr && regAddr == ADDR_ZERO_TIME) begin
        zeroTime_q <= regWdata;
      end
      regRdata <= regRd ? rdMux : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign torqueOff = (state_q == ST_OFF);
  assign torqueOffComplete = complete_q;
  assign restartAllowed = (state_q != ST_OFF) & ~faulted_q;
  assign eventValid = evValid_q;
  assign eventType = evType_q;
  assign driveFaulted = faulted_q;

endmodule : tor_control

//--- verif/tor_partner.sv
/*
  Far-side model: thermal relay contact and the drive that takes events.
  Assumes the bench drives tripReq and driveReset on the system clock.
*/
module tor_partner (
  input wire logic clk_sys, // System clock
  input wire logic tripReq, // Winding overheated
  input wire logic eventValid, // Event pulse from block
  input wire logic [1:0] eventType, // Event severity
  input wire logic driveReset, // Operator resets the drive
  output logic relayOpen, // Relay contact, high is request
  output logic faultSeen // Drive sits in fault
);
  // ---------------------------------------------------------------------------
  // Relay contact and drive fault latch
  // ---------------------------------------------------------------------------
  initial relayOpen = 1'b0;
  initial faultSeen = 1'b0;
  always @(posedge clk_sys) relayOpen <= tripReq;
  always @(posedge clk_sys) begin
    if (eventValid && eventType == 2'h3) faultSeen <= 1'b1;
    else if (driveReset) faultSeen <= 1'b0;
  end
endmodule : tor_partner

//--- verif/tor_control_properties.sv
/*
  Port checker for the torque-off control block.
  Assumes one clock and a synchronous active-high reset.
*/
module tor_control_properties
  import tor_pkg::*;
#(parameter int RESTART_DELAY_DEF = 20, parameter int TIME_TO_ZERO_DEF = 20) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Reset
  input wire logic internalFault, // Internal fault
  input wire logic [ADDR_W-1:0] regAddr, // Address
  input wire logic [31:0] regWdata, // Write data
  input wire logic regWr, // Write strobe
  input wire logic torqueOff, // Torque off
  input wire logic torqueOffComplete, // Completed
  input wire logic restartAllowed, // Restart ok
  input wire logic eventValid, // Event pulse
  input wire logic [1:0] eventType, // Severity
  input wire logic driveFaulted // Drive faulted
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_event_pulse: assert property (eventValid |=> !eventValid) else $error("event too long");
  chk_event_off: assert property (eventValid |-> torqueOff) else $error("event without off");
  chk_fault_latch: assert property (eventValid && eventType == EV_FAULT |-> ##[0:1] driveFaulted)
    else $error("fault not latched");
  chk_plain_clean: assert property (eventValid && eventType != EV_FAULT && !driveFaulted |=> !driveFaulted)
    else $error("plain event faulted");
  chk_fault_hold: assert property (driveFaulted && !(regWr && regAddr == ADDR_CMD && regWdata[0]) |=> driveFaulted)
    else $error("fault dropped");
  chk_fault_keeps: assert property (torqueOff && driveFaulted |=> torqueOff) else $error("faulted off released");
  chk_restart_gate: assert property (restartAllowed |-> !torqueOff && !driveFaulted)
    else $error("restart while blocked");
  chk_internal_off: assert property (internalFault |-> ##[1:3] torqueOff) else $error("internal fault ignored");
  chk_complete_off: assert property (torqueOffComplete |-> torqueOff) else $error("complete outside off");
  chk_complete_late: assert property ($rose(torqueOff) |-> !torqueOffComplete [*8]) else $error("complete early");
endmodule : tor_control_properties
bind tor_control tor_control_properties #(.RESTART_DELAY_DEF(RESTART_DELAY_DEF), .TIME_TO_ZERO_DEF(TIME_TO_ZERO_DEF))
  i_tor_control_properties (.*);

//--- verif/test_torque_off_ack_restart_control.sv
/*
  Bench: register reads, event-type table, then manual, thermal, stop-1, fault and reset cases.
  Assumes short delay parameters of 20 cycles.
*/
module test_torque_off_ack_restart_control import tor_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RDLY = 20;
  logic clk_sys = 0, rst = 1, overTemp = 0, rampLimitHit = 0, internalFault = 0, regWr = 0, regRd = 0, tripReq = 0;
  logic [3:0] tbDi = 0, regAddr = 0;
  logic [31:0] regWdata = 0, regRdata;
  logic torqueOff, torqueOffComplete, restartAllowed, eventValid, driveFaulted, relayOpen, faultSeen;
  logic [1:0] eventType;
  logic [2:0] rows [4] = '{3'b000, 3'b010, 3'b100, 3'b111};
  int n_mismatch = 0, n_tests = 0, n;
  wire [3:0] digIn = {tbDi[3:2], relayOpen, tbDi[0]};
  wire driveReset = regWr && regAddr == ADDR_CMD && regWdata[0];
  tor_control #(.RESTART_DELAY_DEF(RDLY), .TIME_TO_ZERO_DEF(RDLY)) i_tor_control (.clk_sys(clk_sys), .rst(rst),
    .digIn(digIn), .overTemp(overTemp), .rampLimitHit(rampLimitHit), .internalFault(internalFault),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .torqueOff(torqueOff), .torqueOffComplete(torqueOffComplete), .restartAllowed(restartAllowed),
    .eventValid(eventValid), .eventType(eventType), .driveFaulted(driveFaulted));
  tor_partner i_tor_partner (.clk_sys(clk_sys), .tripReq(tripReq), .eventValid(eventValid),
    .eventType(eventType), .driveReset(driveReset), .relayOpen(relayOpen), .faultSeen(faultSeen));
  initial forever #2 clk_sys = ~clk_sys;
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (e !== g) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys) begin regWr <= 1'b1; regAddr <= a; regWdata <= d; end
    @(posedge clk_sys) regWr <= 1'b0;
  endtask : wrReg
  task automatic rdReg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys) begin regRd <= 1'b1; regAddr <= a; end
    @(posedge clk_sys) regRd <= 1'b0;
    @(negedge clk_sys) chk("regRdata", e, regRdata);
  endtask : rdReg
  task automatic waitOff(input logic v);
    n = 0;
    do begin @(negedge clk_sys); n++; end while (torqueOff !== v && n < 200);
    chk("torqueOff", v, torqueOff);
  endtask : waitOff
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    close_out();
  end
  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys) chk("restartAllowed", 1, restartAllowed);
    rdReg(ADDR_CFG, CFG_RESET);
    wrReg(4'hF, 32'hFFFF_FFFF);
    rdReg(4'hF, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wrReg(ADDR_CFG, 32'h0000_0100 | 32'(rows[i][2:1]));
      tbDi[0] <= 1'b1;
      waitOff(1'b1);
      chk("eventValid", 1, eventValid);
      chk("eventType", rows[i][2:1], eventType);
      @(posedge clk_sys) tbDi[0] <= 1'b0;
      repeat (10) @(negedge clk_sys);
      chk("delay held", 1, torqueOff);
      chk("restartAllowed", 0, restartAllowed);
      repeat (20) @(negedge clk_sys);
      chk("faultSeen", rows[i][0], faultSeen);
      chk("held", rows[i][0], torqueOff);
      chk("driveFaulted", rows[i][0], driveFaulted);
      chk("complete", rows[i][0], torqueOffComplete);
      if (rows[i][0]) wrReg(ADDR_CMD, 32'h0000_0001);
      waitOff(1'b0);
    end
    wrReg(ADDR_CFG, 32'h0030_2020);
    tripReq <= 1'b1;
    waitOff(1'b1);
    @(posedge clk_sys) tripReq <= 1'b0;
    repeat (40) @(negedge clk_sys);
    chk("no ack", 1, torqueOff);
    @(posedge clk_sys) tbDi[2] <= 1'b1;
    waitOff(1'b0);
    @(posedge clk_sys) tbDi[2] <= 1'b0;
    wrReg(ADDR_CFG, 32'h0004_0008);
    tbDi[3] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rampLimitHit <= 1'b1;
    waitOff(1'b1);
    chk("ramp event", EV_EVENT, eventType);
    @(posedge clk_sys) begin rampLimitHit <= 1'b0; tbDi[3] <= 1'b0; end
    waitOff(1'b0);
    chk("stop1 fast", 1, n < RDLY);
    wrReg(ADDR_CFG, 32'h0100_0000);
    overTemp <= 1'b1;
    waitOff(1'b1);
    @(posedge clk_sys) overTemp <= 1'b0;
    waitOff(1'b0);
    @(posedge clk_sys) internalFault <= 1'b1;
    waitOff(1'b1);
    @(posedge clk_sys) internalFault <= 1'b0;
    waitOff(1'b0);
    @(posedge clk_sys) internalFault <= 1'b1;
    waitOff(1'b1);
    @(posedge clk_sys) begin internalFault <= 1'b0; rst <= 1'b1; end
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys) chk("reset off", 0, torqueOff);
    rdReg(ADDR_CFG, CFG_RESET);
    close_out();
  end
endmodule : test_torque_off_ack_restart_control
